// *** bench/icpe_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none
module icpe_assertions (
   // Clock and reset
   input  wire logic        clk_sys_in,
   input  wire logic        nrst_in,
   // Bus
   input  wire logic        wb_cyc_in,
   input  wire logic        wb_stb_in,
   input  wire logic        wb_ack_out,
   input  wire logic [31:0] wb_dat_out,
   // Sources and core
   input  wire logic        two_wire_serial_request_in,
   input  wire logic        disable_interrupts_instruction_in,
   input  wire logic        core_exception_ack_in,
   input  wire logic        core_vector_ack_in,
   input  wire logic        vec_req_out,
   input  wire logic [1:0]  vec_level_out,
   input  wire logic        global_interrupt_master_enable_out
);
   wire logic en = global_interrupt_master_enable_out;
   wire logic vq = vec_req_out;
   wire logic va = core_vector_ack_in;
   wire logic kill = disable_interrupts_instruction_in |
                     core_exception_ack_in;
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!nrst_in);
   ////////////////////////////////////////
   property p_ack_one;
      wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out;
   endproperty
   a_ack_one: assert property (p_ack_one)
      else $error("bus request not acknowledged");
   property p_ack_drop;
      wb_ack_out |=> !wb_ack_out;
   endproperty
   a_ack_drop: assert property (p_ack_drop)
      else $error("acknowledge longer than one cycle");
   property p_dat_hi;
      wb_ack_out |-> wb_dat_out[31:8] == 24'h00_0000;
   endproperty
   a_dat_hi: assert property (p_dat_hi)
      else $error("upper read data not zero");
   property p_poll;
      !en [*2] |-> !vq;
   endproperty
   a_poll: assert property (p_poll)
      else $error("vector presented while disabled");
   property p_take;
      vq && va |=> !vq && !en;
   endproperty
   a_take: assert property (p_take)
      else $error("vector take did not clear request");
   property p_lvl;
      vq |-> vec_level_out != 2'h0;
   endproperty
   a_lvl: assert property (p_lvl)
      else $error("vector at disabled level");
   property p_kill;
      kill |=> !en;
   endproperty
   a_kill: assert property (p_kill)
      else $error("master enable not cleared");
   property p_grp1_vec;
      two_wire_serial_request_in && en && !kill && !va
         ##1 en && !kill && !va |=> vq;
   endproperty
   a_grp1_vec: assert property (p_grp1_vec)
      else $error("enabled request not vectored");
   c_take: cover property (vq && va);
   c_read: cover property (wb_ack_out);
   c_kill: cover property (en && kill);
endmodule : icpe_assertions
`default_nettype wire

// *** bench/icpe_core_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module icpe_core_model (
   // Clock and reset
   input  wire logic clk_sys_in,
   input  wire logic nrst_in,
   // Vector handshake
   input  wire logic vec_req_in,
   output logic      vec_ack_out,
   output logic      return_from_interrupt_instruction_out
);
   logic [2:0] cnt_q;
   logic       slow_q;
   logic       busy_q;
   // Prompt and slow service in turn
   always_ff @(posedge clk_sys_in) begin
      vec_ack_out <= 1'b0;
      return_from_interrupt_instruction_out    <= 1'b0;
      if (!nrst_in) begin
         cnt_q  <= 3'h0;
         slow_q <= 1'b0;
         busy_q <= 1'b0;
      end else if (busy_q) begin
         cnt_q <= cnt_q + 3'h1;
         if (cnt_q == (slow_q ? 3'h6 : 3'h1)) begin
            return_from_interrupt_instruction_out <= 1'b1;
            busy_q   <= 1'b0;
            cnt_q    <= 3'h0;
            slow_q   <= !slow_q;
         end
      end else if (vec_req_in) begin
         cnt_q <= cnt_q + 3'h1;
         if (cnt_q >= (slow_q ? 3'h3 : 3'h0)) begin
            vec_ack_out <= 1'b1;
            busy_q      <= 1'b1;
            cnt_q       <= 3'h0;
         end
      end
   end
endmodule : icpe_core_model
`default_nettype wire

// *** bench/test_irq_pending_and_priority_enable.sv ***
`timescale 1ns/100ps
`default_nettype none
module test_irq_pending_and_priority_enable;
   import icpe_pkg::*;
   logic        clk, nrst, cyc, stb, we;
   logic        ack, vreq, gie, irq, vack, return_from_interrupt_instruction;
   logic [13:0] adr;
   logic [31:0] wdat, rdat;
   logic [7:0]  g0, g1, hi, lo;
   logic [2:0]  cmd;
   logic [3:0]  vsrc, sel, wsel;
   logic [1:0]  vlvl;
   int          failures, n_tests, seed, k, lv;
   logic [31:0] rq[$];
   logic [31:0] vq[$];
   initial clk = 1'b0;
   always #2 clk = ~clk;
   icpe_top DUT (.clk_sys_in(clk), .nrst_in(nrst), .wb_cyc_in(cyc),
      .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
      .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat),
      .wb_ack_out(ack), .grp0_src_in(g0),
      .two_wire_serial_request_in(g1[7]),
      .portc_pin0_request_in(g1[5]),
      .portb_low_nibble_request_in(g1[4]),
      .porta_pair_7_3_request_in(g1[3]),
      .porta_pair_6_2_request_in(g1[2]),
      .porta_pair_5_1_request_in(g1[1]),
      .porta_pair_4_0_request_in(g1[0]),
      .enable_interrupts_instruction_in(cmd[0]),
      .disable_interrupts_instruction_in(cmd[1]),
      .return_from_interrupt_instruction_in(return_from_interrupt_instruction),
      .core_vector_ack_in(vack), .core_exception_ack_in(cmd[2]),
      .vec_req_out(vreq), .vec_src_out(vsrc), .vec_level_out(vlvl),
      .global_interrupt_master_enable_out(gie), .irq_out(irq));
   icpe_core_model CORE (.clk_sys_in(clk), .nrst_in(nrst),
      .vec_req_in(vreq), .vec_ack_out(vack), .return_from_interrupt_instruction_out(return_from_interrupt_instruction));
   ////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [11:0] idx,
                      input logic [7:0] d, input logic [7:0] e);
      int n;
      n = 0;
      if (!w) rq.push_back({24'h00_0000, e});
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      sel  <= wsel;
      adr  <= {idx, 2'b00};
      wdat <= {24'h00_0000, d};
      do begin
         @(posedge clk);
         n++;
      end while (!ack && n < 50);
      chk(32'(ack), 1);
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask : bus
   task automatic core_cmd(input logic [2:0] c);
      cmd <= c;
      @(posedge clk);
      cmd <= 3'h0;
      @(posedge clk);
   endtask : core_cmd
   task automatic drain();
      int n;
      n = 0;
      while (vq.size() != 0 && n < 3000) begin
         @(posedge clk);
         n++;
      end
      chk(32'(vq.size()), 0);
   endtask : drain
   task automatic report_and_stop();
      if (failures == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : report_and_stop
   ////////////////////////////////////////
   always @(posedge clk) begin
      if (ack && !we) chk(rdat, rq.pop_front());
      if (vreq && vack)
         chk({26'h000_0000, vlvl, vsrc}, vq.pop_front());
   end
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      report_and_stop();
   end
   initial begin
      seed = 63123;
      wsel = 4'hf;
      failures = 0;
      n_tests = 0;
      {nrst, cyc, stb, we, sel, adr, wdat, g0, g1, cmd} = '0;
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      for (k = 0; k < 4; k++) bus(0, IDX_GRP0_PEND + 12'(k), 0, 0);
      hi = 8'($random(seed));
      lo = 8'($random(seed));
      bus(1, IDX_GRP0_PRIO_H, hi, 0);
      bus(0, IDX_GRP0_PRIO_H, 0, hi);
      // Write with low byte lane off is ignored
      wsel = 4'he;
      bus(1, IDX_GRP0_PRIO_H, ~hi, 0);
      wsel = 4'hf;
      bus(0, IDX_GRP0_PRIO_H, 0, hi);
      bus(1, IDX_GRP0_PRIO_L, lo, 0);
      bus(0, IDX_GRP0_PRIO_L, 0, lo);
      bus(1, IDX_GRP1_PEND, 8'hff, 0);
      bus(0, IDX_GRP1_PEND, 0, 8'hbf);
      bus(1, IDX_GRP1_PEND, 0, 0);
      bus(1, 12'h123, 8'hff, 0);
      bus(0, 12'h123, 0, 0);
      // Polled sources, one at a time
      for (k = 0; k < 8; k++) begin
         g1 <= 8'(1 << k);
         @(posedge clk);
         g1 <= 8'h00;
         bus(0, IDX_GRP1_PEND, 0, 8'(1 << k) & GRP1_WR_MASK);
         bus(1, IDX_GRP1_PEND, 0, 0);
      end
      // Vectored order by level
      g0 <= 8'hff;
      g1 <= 8'hbf;
      @(posedge clk);
      g0 <= 8'h00;
      g1 <= 8'h00;
      for (lv = 3; lv > 0; lv--)
         for (k = 0; k < 8; k++)
            if ({hi[k], lo[k]} == lv[1:0]) vq.push_back(32'(lv * 16 + k));
      for (k = 0; k < 8; k++)
         if (k != 6) vq.push_back(32'(24 + k));
      core_cmd(3'h1);
      drain();
      bus(0, IDX_GRP0_PEND, 0, ~(hi | lo));
      bus(0, IDX_GRP1_PEND, 0, 0);
      // Event status, mask and line
      bus(0, IDX_EVT_STATUS, 0, 8'h07);
      chk(32'(irq), 0);
      bus(1, IDX_EVT_MASK, 8'h02, 0);
      repeat (2) @(posedge clk);
      chk(32'(irq), 1);
      bus(1, IDX_EVT_STATUS, 8'h02, 0);
      bus(0, IDX_EVT_STATUS, 0, 8'h05);
      chk(32'(irq), 0);
      // Master enable causes
      bus(0, IDX_CONTROL, 0, 8'h80);
      g1 <= 8'h80;
      vq.push_back(31);
      @(posedge clk);
      g1 <= 8'h00;
      drain();
      // Software raise of a pending bit is vectored
      vq.push_back(24);
      bus(1, IDX_GRP1_PEND, 8'h01, 0);
      drain();
      repeat (10) @(posedge clk);
      core_cmd(3'h2);
      bus(0, IDX_CONTROL, 0, 0);
      bus(1, IDX_CONTROL, 8'h80, 0);
      bus(0, IDX_CONTROL, 0, 8'h80);
      core_cmd(3'h4);
      bus(0, IDX_CONTROL, 0, 0);
      report_and_stop();
   end
endmodule : test_irq_pending_and_priority_enable
bind icpe_top icpe_assertions u_chk (.clk_sys_in, .nrst_in, .wb_cyc_in,
   .wb_stb_in, .wb_ack_out, .wb_dat_out, .two_wire_serial_request_in,
   .disable_interrupts_instruction_in, .core_exception_ack_in,
   .core_vector_ack_in, .vec_req_out, .vec_level_out,
   .global_interrupt_master_enable_out);
`default_nettype wire

// *** verilog/icpe_pend_bank.sv ***
`timescale 1ns/100ps
`default_nettype none
module icpe_pend_bank
   import icpe_pkg::*;
#(
   parameter logic [7:0] WR_MASK = 8'hff,
   parameter logic [7:0] RST_VAL = 8'h00
) (
   // Clock and reset
   input  wire logic       clk_sys_in,
   input  wire logic       nrst_in,
   // Set, write and clear
   input  wire logic [7:0] hw_set_in,
   input  wire logic       wr_en_in,
   input  wire logic [7:0] wr_data_in,
   input  wire logic [7:0] clr_in,
   // State
   output logic      [7:0] pend_out
);
   ////////////////////////////////////////////////////////////////////
   // One sticky flag per bit
   genvar i;
   generate
      for (i = 0; i < 8; i++) begin : g_bit
         always_ff @(posedge clk_sys_in) begin
            if (!nrst_in) begin
               pend_out[i] <= RST_VAL[i];
            end else if (hw_set_in[i]) begin
               pend_out[i] <= 1'b1;
            end else if (clr_in[i]) begin
               pend_out[i] <= 1'b0;
            end else if (wr_en_in && WR_MASK[i]) begin
               pend_out[i] <= wr_data_in[i];
            end
         end
      end
   endgenerate
endmodule : icpe_pend_bank
`default_nettype wire

// *** verilog/icpe_pkg.sv ***
// Summary of operation
// - Group 1 requests set their pending bits
// - Enabled globally: pending requests at a nonzero level are vectored
// - Disabled globally: no vector, software polls
// - Group 1 pending at FC3, bit 6 reserved
// - Bit 7 holds two-wire serial request
// - Bit 5 holds port C pin 0 request
// - Bit 4 shared by port B pins 3..0
// - Bits 3..0 hold port A pin pairs
// - High/low enable pair decodes priority level
// - Enable bit x pairs with pending bit x
// - High enable register at FC1, resets zero
// - Low enable register at FC2, resets zero
// - Group 0 pending at FC0, resets zero
// - Writing one raises; vectoring clears the bit
// - Master enable set and cleared by events
`default_nettype none
package icpe_pkg;
   ////////////////////////////////////////////////////////////////////
   // Register indices; byte address is four times the index
   localparam logic [11:0] IDX_GRP0_PEND   = 12'hfc0;
   localparam logic [11:0] IDX_GRP0_PRIO_H = 12'hfc1;
   localparam logic [11:0] IDX_GRP0_PRIO_L = 12'hfc2;
   localparam logic [11:0] IDX_GRP1_PEND   = 12'hfc3;
   localparam logic [11:0] IDX_CONTROL     = 12'hfcf;
   localparam logic [11:0] IDX_EVT_STATUS  = 12'hfd0;
   localparam logic [11:0] IDX_EVT_MASK    = 12'hfd1;
   ////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [7:0] RST_GRP0_PEND   = 8'h00;
   localparam logic [7:0] RST_GRP0_PRIO   = 8'h00;
   localparam logic [7:0] RST_GRP1_PEND   = 8'h00;
   localparam logic       RST_MASTER_EN   = 1'b0;
   localparam logic [2:0] RST_EVT         = 3'h0;
   ////////////////////////////////////////////////////////////////////
   // Group 1 pending fields and write masks
   localparam int GRP1_TWO_WIRE_BIT = 7;
   localparam int GRP1_RESERVED_BIT = 6;
   localparam int GRP1_PORTC0_BIT   = 5;
   localparam int GRP1_PORTB_BIT    = 4;
   localparam int GRP1_PA73_BIT     = 3;
   localparam int GRP1_PA62_BIT     = 2;
   localparam int GRP1_PA51_BIT     = 1;
   localparam int GRP1_PA40_BIT     = 0;
   localparam logic [7:0] GRP1_WR_MASK = 8'hbf;
   localparam logic [7:0] GRP0_WR_MASK = 8'hff;
   ////////////////////////////////////////////////////////////////////
   // Control and event fields
   localparam int CTRL_MASTER_EN_BIT = 7;
   localparam int EVT_GRP0_BIT       = 0;
   localparam int EVT_GRP1_BIT       = 1;
   localparam int EVT_VECTOR_BIT     = 2;
   ////////////////////////////////////////////////////////////////////
   // Priority levels
   localparam logic [1:0] LVL_DISABLED = 2'h0;
   localparam logic [1:0] LVL_GRP1     = 2'h1;
endpackage : icpe_pkg
`default_nettype wire

// *** verilog/icpe_prio_pick.sv ***
`timescale 1ns/100ps
`default_nettype none
module icpe_prio_pick
   import icpe_pkg::*;
(
   // Requests with their levels
   input  wire logic [15:0] lvl_valid_in,
   input  wire logic [31:0] lvl_in,
   // Winner
   output logic      [3:0]  best_idx_out,
   output logic      [1:0]  best_lvl_out
);
   ////////////////////////////////////////////////////////////////////
   // Strictly higher level wins, so lowest index wins ties
   always_comb begin
      best_idx_out = 4'h0;
      best_lvl_out = LVL_DISABLED;
      for (int i = 0; i < 16; i++) begin
         if (lvl_valid_in[i] && (lvl_in[2*i +: 2] > best_lvl_out)) begin
            best_idx_out = 4'(i);
            best_lvl_out = lvl_in[2*i +: 2];
         end
      end
   end
endmodule : icpe_prio_pick
`default_nettype wire

// *** verilog/icpe_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module icpe_top
   import icpe_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_sys_in,
   input  wire logic        nrst_in,
   // Wishbone slave
   input  wire logic        wb_cyc_in,
   input  wire logic        wb_stb_in,
   input  wire logic        wb_we_in,
   input  wire logic [13:0] wb_adr_in,
   input  wire logic [3:0]  wb_sel_in,
   input  wire logic [31:0] wb_dat_in,
   output logic      [31:0] wb_dat_out,
   output logic             wb_ack_out,
   // Group 0 sources, bit 7 down to 0
   input  wire logic [7:0]  grp0_src_in,
   // Group 1 sources
   input  wire logic        two_wire_serial_request_in,
   input  wire logic        portc_pin0_request_in,
   input  wire logic        portb_low_nibble_request_in,
   input  wire logic        porta_pair_7_3_request_in,
   input  wire logic        porta_pair_6_2_request_in,
   input  wire logic        porta_pair_5_1_request_in,
   input  wire logic        porta_pair_4_0_request_in,
   // Processor core
   input  wire logic        enable_interrupts_instruction_in,
   input  wire logic        disable_interrupts_instruction_in,
   input  wire logic        return_from_interrupt_instruction_in,
   input  wire logic        core_vector_ack_in,
   input  wire logic        core_exception_ack_in,
   output logic             vec_req_out,
   output logic      [3:0]  vec_src_out,
   output logic      [1:0]  vec_level_out,
   output logic             global_interrupt_master_enable_out,
   // Block interrupt
   output logic             irq_out
);
   ////////////////////////////////////////////////////////////////////
   // Bus decode
   logic [11:0] reg_idx;
   logic        bus_req;
   logic        bus_wr;
   logic        ack_d;
   logic [31:0] rdata_d;

   assign reg_idx = wb_adr_in[13:2];
   assign bus_req = wb_cyc_in && wb_stb_in;
   // Write lands on the edge where ack is seen high
   assign bus_wr  = bus_req && wb_we_in && wb_ack_out && wb_sel_in[0];
   assign ack_d   = bus_req && !wb_ack_out;

   logic wr_grp0_pend;
   logic wr_prio_h;
   logic wr_prio_l;
   logic wr_grp1_pend;
   logic wr_ctrl;
   logic wr_evt_status;
   logic wr_evt_mask;

   assign wr_grp0_pend  = bus_wr && (reg_idx == IDX_GRP0_PEND);
   assign wr_prio_h     = bus_wr && (reg_idx == IDX_GRP0_PRIO_H);
   assign wr_prio_l     = bus_wr && (reg_idx == IDX_GRP0_PRIO_L);
   assign wr_grp1_pend  = bus_wr && (reg_idx == IDX_GRP1_PEND);
   assign wr_ctrl       = bus_wr && (reg_idx == IDX_CONTROL);
   assign wr_evt_status = bus_wr && (reg_idx == IDX_EVT_STATUS);
   assign wr_evt_mask   = bus_wr && (reg_idx == IDX_EVT_MASK);

   ////////////////////////////////////////////////////////////////////
   // Priority enable registers
   logic [7:0] prio_high_q;
   logic [7:0] prio_low_q;

   always_ff @(posedge clk_sys_in) begin
      if (!nrst_in) begin
         prio_high_q <= RST_GRP0_PRIO;
      end else if (wr_prio_h) begin
         prio_high_q <= wb_dat_in[7:0];
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!nrst_in) begin
         prio_low_q <= RST_GRP0_PRIO;
      end else if (wr_prio_l) begin
         prio_low_q <= wb_dat_in[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Vector acknowledge clears
   logic       vec_taken;
   logic [7:0] clr_bit;
   logic [7:0] grp0_clr;
   logic [7:0] grp1_clr;

   assign vec_taken = core_vector_ack_in && vec_req_out;
   assign clr_bit   = 8'h01 << vec_src_out[2:0];
   assign grp0_clr  = (vec_taken && !vec_src_out[3]) ? clr_bit : 8'h00;
   assign grp1_clr  = (vec_taken && vec_src_out[3]) ? clr_bit : 8'h00;

   ////////////////////////////////////////////////////////////////////
   // Pending registers
   logic [7:0] grp1_set;
   logic [7:0] grp0_pend;
   logic [7:0] grp1_pend;

   always_comb begin
      grp1_set                    = 8'h00;
      grp1_set[GRP1_TWO_WIRE_BIT] = two_wire_serial_request_in;
      grp1_set[GRP1_RESERVED_BIT] = 1'b0;
      grp1_set[GRP1_PORTC0_BIT]   = portc_pin0_request_in;
      grp1_set[GRP1_PORTB_BIT]    = portb_low_nibble_request_in;
      grp1_set[GRP1_PA73_BIT]     = porta_pair_7_3_request_in;
      grp1_set[GRP1_PA62_BIT]     = porta_pair_6_2_request_in;
      grp1_set[GRP1_PA51_BIT]     = porta_pair_5_1_request_in;
      grp1_set[GRP1_PA40_BIT]     = porta_pair_4_0_request_in;
   end

   icpe_pend_bank #(
      .WR_MASK (GRP0_WR_MASK),
      .RST_VAL (RST_GRP0_PEND)
   ) u_grp0_pend (
      .clk_sys_in (clk_sys_in),
      .nrst_in    (nrst_in),
      .hw_set_in  (grp0_src_in),
      .wr_en_in   (wr_grp0_pend),
      .wr_data_in (wb_dat_in[7:0]),
      .clr_in     (grp0_clr),
      .pend_out   (grp0_pend)
   );

   icpe_pend_bank #(
      .WR_MASK (GRP1_WR_MASK),
      .RST_VAL (RST_GRP1_PEND)
   ) u_grp1_pend (
      .clk_sys_in (clk_sys_in),
      .nrst_in    (nrst_in),
      .hw_set_in  (grp1_set),
      .wr_en_in   (wr_grp1_pend),
      .wr_data_in (wb_dat_in[7:0]),
      .clr_in     (grp1_clr),
      .pend_out   (grp1_pend)
   );

   ////////////////////////////////////////////////////////////////////
   // Level decode per source
   logic [15:0] lvl_valid;
   logic [31:0] lvl_all;
   logic [3:0]  best_idx;
   logic [1:0]  best_lvl;

   genvar x;
   generate
      for (x = 0; x < 8; x++) begin : g_lvl
         assign lvl_valid[x]         = grp0_pend[x];
         assign lvl_all[2*x +: 2]    = {prio_high_q[x], prio_low_q[x]};
         assign lvl_valid[x + 8]     = grp1_pend[x];
         assign lvl_all[2*x+16 +: 2] = LVL_GRP1;
      end
   endgenerate

   icpe_prio_pick u_pick (
      .lvl_valid_in (lvl_valid),
      .lvl_in       (lvl_all),
      .best_idx_out (best_idx),
      .best_lvl_out (best_lvl)
   );

   ////////////////////////////////////////////////////////////////////
   // Master enable
   logic master_en_d;

   always_comb begin
      master_en_d = global_interrupt_master_enable_out;
      if (wr_ctrl) begin
         master_en_d = wb_dat_in[CTRL_MASTER_EN_BIT];
      end
      if (enable_interrupts_instruction_in
          || return_from_interrupt_instruction_in) begin
         master_en_d = 1'b1;
      end
      if (disable_interrupts_instruction_in || vec_taken
          || core_exception_ack_in) begin
         master_en_d = 1'b0;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!nrst_in) begin
         global_interrupt_master_enable_out <= RST_MASTER_EN;
      end else begin
         global_interrupt_master_enable_out <= master_en_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Vector request to the core
   logic vec_req_d;

   assign vec_req_d = global_interrupt_master_enable_out
                      && (best_lvl != LVL_DISABLED)
                      && !vec_taken;

   always_ff @(posedge clk_sys_in) begin
      if (!nrst_in) begin
         vec_req_out <= 1'b0;
      end else begin
         vec_req_out <= vec_req_d;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!nrst_in) begin
         vec_src_out   <= 4'h0;
         vec_level_out <= LVL_DISABLED;
      end else if (vec_req_d) begin
         vec_src_out   <= best_idx;
         vec_level_out <= best_lvl;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Block events, sticky, write one to clear
   logic [2:0] evt_status_q;
   logic [2:0] evt_mask_q;
   logic [2:0] evt_set;

   assign evt_set[EVT_GRP0_BIT]   = |grp0_src_in;
   assign evt_set[EVT_GRP1_BIT]   = |grp1_set;
   assign evt_set[EVT_VECTOR_BIT] = vec_taken;

   genvar e;
   generate
      for (e = 0; e < 3; e++) begin : g_evt
         always_ff @(posedge clk_sys_in) begin
            if (!nrst_in) begin
               evt_status_q[e] <= RST_EVT[e];
            end else if (evt_set[e]) begin
               evt_status_q[e] <= 1'b1;
            end else if (wr_evt_status && wb_dat_in[e]) begin
               evt_status_q[e] <= 1'b0;
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_sys_in) begin
      if (!nrst_in) begin
         evt_mask_q <= RST_EVT;
      end else if (wr_evt_mask) begin
         evt_mask_q <= wb_dat_in[2:0];
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!nrst_in) begin
         irq_out <= 1'b0;
      end else begin
         irq_out <= |(evt_status_q & evt_mask_q);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Read back
   always_comb begin
      rdata_d = 32'h0000_0000;
      unique case (reg_idx)
         IDX_GRP0_PEND: begin
            rdata_d[7:0] = grp0_pend;
         end
         IDX_GRP0_PRIO_H: begin
            rdata_d[7:0] = prio_high_q;
         end
         IDX_GRP0_PRIO_L: begin
            rdata_d[7:0] = prio_low_q;
         end
         IDX_GRP1_PEND: begin
            rdata_d[7:0] = grp1_pend;
         end
         IDX_CONTROL: begin
            rdata_d[CTRL_MASTER_EN_BIT] = global_interrupt_master_enable_out;
         end
         IDX_EVT_STATUS: begin
            rdata_d[2:0] = evt_status_q;
         end
         IDX_EVT_MASK: begin
            rdata_d[2:0] = evt_mask_q;
         end
         default: begin
            rdata_d = 32'h0000_0000;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // Bus answer
   always_ff @(posedge clk_sys_in) begin
      if (!nrst_in) begin
         wb_ack_out <= 1'b0;
      end else begin
         wb_ack_out <= ack_d;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!nrst_in) begin
         wb_dat_out <= 32'h0000_0000;
      end else if (ack_d) begin
         wb_dat_out <= rdata_d;
      end
   end
endmodule : icpe_top
`default_nettype wire
